// [include/fcesr_pkg.sv]
// Shared constants and types of the flash card host controller.
// Assumes a 40 MHz clock; all waits are rounded up to whole cycles.
package fcesr_pkg;
  // Clock and widths
  localparam int CLK_NS = 25;
  localparam int ADDR_W = 25;
  localparam int DQ_W   = 16;
  localparam int LANE_W = 8;
  localparam int NLANE  = 2;
  localparam int TMR_W  = 10;
  localparam int IDX_W  = 3;

  // Times in ns, cycle counts derived (round up: all are least times)
  localparam int T_RST_LOW_NS  = 500;
  localparam int T_RST_DONE_NS = 20000;
  localparam int T_WAKE_NS     = 500;
  localparam int T_SUSP_NS     = 15000;
  localparam int T_PULSE_NS    = 8000;
  localparam int T_SETUP_NS    = 50;
  localparam int T_STROBE_NS   = 200;
  localparam logic [TMR_W-1:0] RST_LOW_CNT =
    TMR_W'((T_RST_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] RST_DONE_CNT =
    TMR_W'((T_RST_DONE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] WAKE_CNT =
    TMR_W'((T_WAKE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] SUSP_CNT =
    TMR_W'((T_SUSP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] PULSE_CNT =
    TMR_W'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] SETUP_CNT =
    TMR_W'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] STROBE_CNT =
    TMR_W'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] TMR_ONE = TMR_W'(1);

  // Card command words (doubled on both lanes) and unlock addresses
  localparam logic [DQ_W-1:0]   CMD_UNLOCK1 = 16'hAAAA;
  localparam logic [DQ_W-1:0]   CMD_UNLOCK2 = 16'h5555;
  localparam logic [DQ_W-1:0]   CMD_PROG    = 16'hA0A0;
  localparam logic [DQ_W-1:0]   CMD_ESETUP  = 16'h8080;
  localparam logic [DQ_W-1:0]   CMD_SECTOR  = 16'h3030;
  localparam logic [DQ_W-1:0]   CMD_SUSPEND = 16'hB0B0;
  localparam logic [DQ_W-1:0]   CMD_RESUME  = 16'h3030;
  localparam logic [ADDR_W-1:0] UNLOCK_A1   = 25'h0005555;
  localparam logic [ADDR_W-1:0] UNLOCK_A2   = 25'h0002AAA;

  // Sequence lengths in bus cycles
  localparam logic [IDX_W-1:0] PROG_LEN  = 3'h4;
  localparam logic [IDX_W-1:0] ERASE_LEN = 3'h6;
  localparam logic [IDX_W-1:0] ONE_LEN   = 3'h1;

  // Status bit positions inside one byte lane
  localparam int POLL_BIT    = 7;
  localparam int TIMEOUT_BIT = 5;

  // Register map of the controller
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] REG_CTRL   = 8'h00;
  localparam logic [REG_AW-1:0] REG_ADDR   = 8'h04;
  localparam logic [REG_AW-1:0] REG_DATA   = 8'h08;
  localparam logic [REG_AW-1:0] REG_STATUS = 8'h0C;
  localparam logic [REG_AW-1:0] REG_RDATA  = 8'h10;

  // Status register fields
  localparam int ST_BUSY    = 0;
  localparam int ST_SUSP    = 1;
  localparam int ST_ERASE   = 2;
  localparam int ST_DONE    = 3;
  localparam int ST_FAIL    = 5;
  localparam int ST_REFUSED = 7;
  localparam int ST_CONFIRM = 8;
  localparam int ST_RDY     = 9;

  // Operations written to the control register
  typedef enum logic [2:0] {
    OP_NONE   = 3'h0,
    OP_READ   = 3'h1,
    OP_PROG   = 3'h2,
    OP_ERASE  = 3'h3,
    OP_SUSP   = 3'h4,
    OP_RESUME = 3'h5,
    OP_POLL   = 3'h6,
    OP_RESET  = 3'h7
  } fcesr_op_t;

  // Software register port request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [REG_AW-1:0] addr;
    logic [31:0]       wdata;
  } fcesr_req_t;

  // Card memory interface pins driven by the host
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0]   dq_out;
    logic              dq_oe_n;
    logic              we_n;
    logic              oe_n;
    logic              ce_n;
  } fcesr_pins_t;
endpackage

// [hw/fcesr_cycle.sv]
// One card bus cycle, write or read, with setup, strobe and hold phases.
// Assumes the card answers reads within the strobe time.
`timescale 1ns/100ps
module fcesr_cycle (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    start,
  input  wire logic                    wr,
  input  wire logic [fcesr_pkg::ADDR_W-1:0] addr,
  input  wire logic [fcesr_pkg::DQ_W-1:0]   wdata,
  input  wire logic [fcesr_pkg::DQ_W-1:0]   dq_in,
  output fcesr_pkg::fcesr_pins_t       pins,
  output logic                         done,
  output logic [fcesr_pkg::DQ_W-1:0]   rdata
);
  import fcesr_pkg::*;

  typedef enum logic [1:0] {
    CY_IDLE   = 2'h0,
    CY_SETUP  = 2'h1,
    CY_STROBE = 2'h2,
    CY_HOLD   = 2'h3
  } fcesr_cy_t;

  localparam fcesr_pins_t PINS_IDLE = '{addr: '0, dq_out: '0,
    dq_oe_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, ce_n: 1'b1};

  fcesr_cy_t         st_r, st_nxt;
  logic [TMR_W-1:0]  cnt_r, cnt_nxt;
  fcesr_pins_t       pins_r, pins_nxt;
  logic              done_r, done_nxt;
  logic [DQ_W-1:0]   rdata_r, rdata_nxt;

  // Phase sequencing of a single access
  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    pins_nxt  = pins_r;
    done_nxt  = 1'b0;
    rdata_nxt = rdata_r;
    case (st_r)
      CY_IDLE: begin
        if (start) begin
          pins_nxt.addr    = addr;
          pins_nxt.dq_out  = wdata;
          pins_nxt.dq_oe_n = ~wr;     // Drive data only on writes
          pins_nxt.ce_n    = 1'b0;
          cnt_nxt          = SETUP_CNT;
          st_nxt           = CY_SETUP;
        end
      end
      CY_SETUP: begin
        cnt_nxt = cnt_r - TMR_ONE;
        if (cnt_r == TMR_ONE) begin
          pins_nxt.oe_n = ~pins_r.dq_oe_n;
          pins_nxt.we_n = pins_r.dq_oe_n;
          cnt_nxt       = STROBE_CNT;
          st_nxt        = CY_STROBE;
        end
      end
      CY_STROBE: begin
        cnt_nxt = cnt_r - TMR_ONE;
        if (cnt_r == TMR_ONE) begin
          rdata_nxt     = dq_in;        // Sample before strobe rises
          pins_nxt.we_n = 1'b1;
          pins_nxt.oe_n = 1'b1;
          st_nxt        = CY_HOLD;
        end
      end
      CY_HOLD: begin
        pins_nxt = PINS_IDLE;
        done_nxt = 1'b1;
        st_nxt   = CY_IDLE;
      end
      default: st_nxt = CY_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= CY_IDLE;
      cnt_r   <= '0;
      pins_r  <= PINS_IDLE;
      done_r  <= 1'b0;
      rdata_r <= '0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      pins_r  <= pins_nxt;
      done_r  <= done_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign pins  = pins_r;
  assign done  = done_r;
  assign rdata = rdata_r;
endmodule

// [hw/fcesr_host.sv]
// Host controller for a word-wide flash card: command sequences, erase
// suspend/resume, per-lane status polling and hardware reset.
// Assumes software owns the register port and the card sits on the pins.
// Functional notes
// - Suspension confirmed by polling bit high at the erasing sector.
// - Reads while suspended target other sectors; host does not check.
// - Suspend-program completion found by polling bit at program address.
// - Resume sent only while suspended; suspend allowed again after.
// - No access until 500 ns after reset release.
// - Word program uses doubled command; each lane polled independently.
// - Six-cycle word erase; each lane checked separately.
// - Timing-exceeded seen: polling bit read again before failing.
`timescale 1ns/100ps
module fcesr_host (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  fcesr_pkg::fcesr_req_t            reg_req,
  output logic [31:0]                      reg_rdata,
  output fcesr_pkg::fcesr_pins_t           card_pins,
  input  wire logic [fcesr_pkg::DQ_W-1:0]  card_dq_in,
  input  wire logic                        ready_busy_output,
  output logic                             card_reset_n
);
  import fcesr_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE     = 3'h0,
    H_RST_LOW  = 3'h1,
    H_RST_WAIT = 3'h2,
    H_SEQ      = 3'h3,
    H_SEQ_WAIT = 3'h4,
    H_TIMER    = 3'h5,
    H_RD       = 3'h6,
    H_RD_WAIT  = 3'h7
  } fcesr_hst_t;

  // Address of sequence step
  function automatic logic [ADDR_W-1:0] seq_addr(
    input fcesr_op_t op, input logic [IDX_W-1:0] i,
    input logic [ADDR_W-1:0] a);
    logic last;
    last = (op == OP_PROG) ? (i == PROG_LEN - ONE_LEN)
                           : (i == ERASE_LEN - ONE_LEN);
    if (op == OP_SUSP || op == OP_RESUME || last)
      seq_addr = a;
    else if (i == 3'h1 || i == 3'h4)
      seq_addr = UNLOCK_A2;
    else
      seq_addr = UNLOCK_A1;
  endfunction

  // Data word of sequence step; command words doubled on both lanes, program data as given
  function automatic logic [DQ_W-1:0] seq_data(
    input fcesr_op_t op, input logic [IDX_W-1:0] i,
    input logic [DQ_W-1:0] d);
    case (op)
      OP_SUSP:   seq_data = CMD_SUSPEND;
      OP_RESUME: seq_data = CMD_RESUME;
      OP_PROG: begin
        case (i)
          3'h0:    seq_data = CMD_UNLOCK1;
          3'h1:    seq_data = CMD_UNLOCK2;
          3'h2:    seq_data = CMD_PROG;
          default: seq_data = d;
        endcase
      end
      default: begin
        case (i)
          3'h0, 3'h3: seq_data = CMD_UNLOCK1;
          3'h1, 3'h4: seq_data = CMD_UNLOCK2;
          3'h2:       seq_data = CMD_ESETUP;
          default:    seq_data = CMD_SECTOR;
        endcase
      end
    endcase
  endfunction

  fcesr_hst_t          st_r, st_nxt;
  fcesr_op_t           op_r, op_nxt;
  logic [TMR_W-1:0]    tmr_r, tmr_nxt;
  logic [IDX_W-1:0]    idx_r, idx_nxt, len_r, len_nxt;
  logic [ADDR_W-1:0]   addr_r, addr_nxt;
  logic [DQ_W-1:0]     data_r, data_nxt, rd_r, rd_nxt;
  logic [NLANE-1:0]    done_r, done_nxt, fail_r, fail_nxt;
  logic                recheck_r, recheck_nxt, susp_r, susp_nxt;
  logic                erase_r, erase_nxt, refused_r, refused_nxt;
  logic                confirm_r, confirm_nxt, rst_out_r, rst_out_nxt;
  logic                cy_start_r, cy_start_nxt, cy_wr_r, cy_wr_nxt;
  logic [31:0]         rdata_r, rdata_nxt;
  logic [ADDR_W-1:0]   cy_addr_r, cy_addr_nxt;
  logic [DQ_W-1:0]     cy_data_r, cy_data_nxt;
  logic                cy_done;
  logic [DQ_W-1:0]     cy_rdata;
  fcesr_op_t           req_op;
  logic                accept;
  logic [NLANE-1:0]    ok_l, to_l, left_l;
  logic                exp_bit;

  // One bus cycle at a time toward the card
  fcesr_cycle u_cycle (
    .clk   (clk),
    .rst_n (rst_n),
    .start (cy_start_r),
    .wr    (cy_wr_r),
    .addr  (cy_addr_r),
    .wdata (cy_data_r),
    .dq_in (card_dq_in),
    .pins  (card_pins),
    .done  (cy_done),
    .rdata (cy_rdata)
  );

  // Acceptance of software orders, mirroring the card's gating of erase, suspend and resume
  always_comb begin
    req_op = fcesr_op_t'(reg_req.wdata[2:0]);
    case (req_op)
      OP_ERASE:  accept = !susp_r && !erase_r;
      OP_SUSP:   accept = erase_r && !susp_r;
      OP_RESUME: accept = susp_r;
      OP_NONE:   accept = 1'b0;
      default:   accept = 1'b1;
    endcase
  end

  // Per-lane status decode of the last card read
  always_comb begin
    exp_bit = 1'b1;
    for (int l = 0; l < NLANE; l++) begin
      // Program expects true data bit; erase and suspend expect one
      exp_bit = (op_r == OP_PROG || (op_r == OP_POLL && !erase_r))
        ? data_r[l*LANE_W+POLL_BIT] : 1'b1;
      ok_l[l] = cy_rdata[l*LANE_W+POLL_BIT] == exp_bit;
      to_l[l] = cy_rdata[l*LANE_W+TIMEOUT_BIT];
    end
    left_l = ~(done_r | ok_l);
  end

  // Main sequencer and register file
  always_comb begin
    st_nxt = st_r;  op_nxt = op_r;  tmr_nxt = tmr_r;
    idx_nxt = idx_r;  len_nxt = len_r;  addr_nxt = addr_r;
    data_nxt = data_r;  rd_nxt = rd_r;  done_nxt = done_r;
    fail_nxt = fail_r;  recheck_nxt = recheck_r;  susp_nxt = susp_r;
    erase_nxt = erase_r;  refused_nxt = refused_r;
    confirm_nxt = confirm_r;  rst_out_nxt = rst_out_r;
    cy_start_nxt = 1'b0;  cy_wr_nxt = cy_wr_r;
    cy_addr_nxt = cy_addr_r;  cy_data_nxt = cy_data_r;
    rdata_nxt = 32'h0000_0000;
    // Register reads answer one cycle later
    if (reg_req.rd) begin
      case (reg_req.addr)
        REG_ADDR:   rdata_nxt = 32'(addr_r);
        REG_DATA:   rdata_nxt = 32'(data_r);
        REG_RDATA:  rdata_nxt = 32'(rd_r);
        REG_CTRL:   rdata_nxt = 32'(op_r);
        REG_STATUS: begin
          rdata_nxt[ST_BUSY]              = st_r != H_IDLE;
          rdata_nxt[ST_SUSP]              = susp_r;
          rdata_nxt[ST_ERASE]             = erase_r;
          rdata_nxt[ST_DONE+:NLANE]       = done_r;
          rdata_nxt[ST_FAIL+:NLANE]       = fail_r;
          rdata_nxt[ST_REFUSED]           = refused_r;
          rdata_nxt[ST_CONFIRM]           = confirm_r;
          rdata_nxt[ST_RDY]               = ready_busy_output;
        end
        default:    rdata_nxt = 32'h0000_0000;
      endcase
    end
    if (reg_req.wr && st_r == H_IDLE) begin
      if (reg_req.addr == REG_ADDR) addr_nxt = reg_req.wdata[ADDR_W-1:0];
      if (reg_req.addr == REG_DATA) data_nxt = reg_req.wdata[DQ_W-1:0];
    end
    case (st_r)
      H_IDLE: begin
        if (reg_req.wr && reg_req.addr == REG_CTRL) begin
          refused_nxt = !accept;
          if (accept) begin
            op_nxt = req_op;  idx_nxt = '0;  recheck_nxt = 1'b0;
            done_nxt = '0;  fail_nxt = '0;
            len_nxt = (req_op == OP_PROG) ? PROG_LEN
                    : (req_op == OP_ERASE) ? ERASE_LEN : ONE_LEN;
            if (req_op == OP_RESET) begin
              rst_out_nxt = 1'b0;
              tmr_nxt     = RST_LOW_CNT;
              st_nxt      = H_RST_LOW;
            end else if (req_op == OP_READ || req_op == OP_POLL)
              st_nxt = H_RD;
            else
              st_nxt = H_SEQ;
          end
        end
      end
      H_RST_LOW: begin
        tmr_nxt = tmr_r - TMR_ONE;
        if (tmr_r == TMR_ONE) begin
          rst_out_nxt = 1'b1;
          // Wait for internal reset, which also covers wake-up time
          tmr_nxt = RST_DONE_CNT - RST_LOW_CNT;
          st_nxt  = H_RST_WAIT;
        end
      end
      H_RST_WAIT: begin
        tmr_nxt = tmr_r - TMR_ONE;
        if (tmr_r == TMR_ONE) begin
          susp_nxt = 1'b0;  erase_nxt = 1'b0;
          st_nxt   = H_IDLE;
        end
      end
      H_SEQ: begin
        cy_start_nxt = 1'b1;  cy_wr_nxt = 1'b1;
        cy_addr_nxt = seq_addr(op_r, idx_r, addr_r);
        cy_data_nxt = seq_data(op_r, idx_r, data_r);
        st_nxt = H_SEQ_WAIT;
      end
      H_SEQ_WAIT: begin
        if (cy_done) begin
          idx_nxt = idx_r + ONE_LEN;
          if (idx_r + ONE_LEN != len_r) st_nxt = H_SEQ;
          else begin
            case (op_r)
              OP_ERASE: begin erase_nxt = 1'b1; st_nxt = H_IDLE; end
              OP_RESUME: begin
                susp_nxt = 1'b0;
                st_nxt   = H_IDLE;
              end
              OP_SUSP: begin
                susp_nxt = 1'b1;
                tmr_nxt = SUSP_CNT;
                st_nxt  = H_TIMER;
              end
              default: begin
                tmr_nxt = PULSE_CNT;
                st_nxt  = H_TIMER;
              end
            endcase
          end
        end
      end
      H_TIMER: begin
        tmr_nxt = tmr_r - TMR_ONE;
        if (tmr_r == TMR_ONE) st_nxt = H_RD;
      end
      H_RD: begin
        cy_start_nxt = 1'b1;  cy_wr_nxt = 1'b0;
        cy_addr_nxt = addr_r;
        st_nxt = H_RD_WAIT;
      end
      H_RD_WAIT: begin
        if (cy_done) begin
          rd_nxt = cy_rdata;
          st_nxt = H_IDLE;
          if (op_r == OP_SUSP) confirm_nxt = &ok_l;
          else if (op_r != OP_READ) begin
            done_nxt = done_r | ok_l;
            if (!recheck_r && |(left_l & to_l)) begin
              recheck_nxt = 1'b1;
              st_nxt = H_RD;
            end else begin
              fail_nxt = left_l & to_l;
              recheck_nxt = 1'b0;
              if (op_r == OP_POLL && erase_r && !susp_r &&
                  (left_l & ~to_l) == '0)
                erase_nxt = 1'b0;
              if (op_r == OP_PROG && (left_l & ~to_l) != '0) begin
                tmr_nxt = PULSE_CNT;
                st_nxt  = H_TIMER;
              end
            end
          end
        end
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= H_IDLE;  op_r <= OP_NONE;  tmr_r <= '0;
      idx_r <= '0;  len_r <= '0;  addr_r <= '0;  data_r <= '0;
      rd_r <= '0;  done_r <= '0;  fail_r <= '0;  recheck_r <= 1'b0;
      susp_r <= 1'b0;  erase_r <= 1'b0;  refused_r <= 1'b0;
      confirm_r <= 1'b0;  rst_out_r <= 1'b1;  cy_start_r <= 1'b0;
      cy_wr_r <= 1'b0;  cy_addr_r <= '0;  cy_data_r <= '0;
      rdata_r <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;  op_r <= op_nxt;  tmr_r <= tmr_nxt;
      idx_r <= idx_nxt;  len_r <= len_nxt;  addr_r <= addr_nxt;
      data_r <= data_nxt;  rd_r <= rd_nxt;  done_r <= done_nxt;
      fail_r <= fail_nxt;  recheck_r <= recheck_nxt;
      susp_r <= susp_nxt;  erase_r <= erase_nxt;
      refused_r <= refused_nxt;  confirm_r <= confirm_nxt;
      rst_out_r <= rst_out_nxt;  cy_start_r <= cy_start_nxt;
      cy_wr_r <= cy_wr_nxt;  cy_addr_r <= cy_addr_nxt;
      cy_data_r <= cy_data_nxt;  rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata    = rdata_r;
  assign card_reset_n = rst_out_r;
endmodule

// [verification/fcesr_monitor.sv]
// Checker of the host's card bus shape, reset and suspend timing.
// Sees only the host ports; bound to every host instance below.
`timescale 1ns/100ps
module fcesr_monitor (
  input wire logic              clk,
  input wire logic              rst_n,
  input fcesr_pkg::fcesr_req_t  reg_req,
  input wire logic [31:0]       reg_rdata,
  input fcesr_pkg::fcesr_pins_t card_pins,
  input wire logic [15:0]       card_dq_in,
  input wire logic              ready_busy_output,
  input wire logic              card_reset_n
);
  import fcesr_pkg::*;
  logic [4:0] lo_r, lo_nxt;
  logic [9:0] fall_r, fall_nxt, sus_r, sus_nxt;
  logic       we_r;
  // Saturating counts: reset low, since reset fall, since suspend
  always_comb begin
    lo_nxt = card_reset_n ? 5'h00 : lo_r + 5'(lo_r != 5'h1F);
    fall_nxt = fall_r + 10'(fall_r != 10'h3FF);
    sus_nxt = sus_r + 10'(sus_r != 10'h3FF);
    if (!card_reset_n && lo_r == 5'h00) fall_nxt = 10'h000;
    if (!card_pins.we_n && we_r && card_pins.dq_out == CMD_SUSPEND)
      sus_nxt = 10'h000;
  end
  // Register the counts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_r <= 5'h00;
      fall_r <= 10'h3FF;
      sus_r <= 10'h3FF;
      we_r <= 1'b1;
    end else begin
      lo_r <= lo_nxt;
      fall_r <= fall_nxt;
      sus_r <= sus_nxt;
      we_r <= card_pins.we_n;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Strobe phases of one card cycle
  sequence we_low8;
    !card_pins.we_n [*8] ##1 card_pins.we_n;
  endsequence
  sequence oe_low8;
    (!card_pins.oe_n && card_pins.dq_oe_n) [*8] ##1 card_pins.oe_n;
  endsequence
  chk_write_pulse: assert property (
    $fell(card_pins.we_n) |-> we_low8) else $error("write strobe bad");
  chk_read_pulse: assert property (
    $fell(card_pins.oe_n) |-> oe_low8) else $error("read strobe bad");
  chk_write_setup: assert property (
    $fell(card_pins.we_n) |-> !card_pins.ce_n && !card_pins.dq_oe_n
      && $past(!card_pins.ce_n, 2)) else $error("write setup short");
  chk_wdata_hold: assert property (
    !card_pins.we_n && $past(!card_pins.we_n) |->
      $stable(card_pins.addr) && $stable(card_pins.dq_out))
    else $error("write data moved");
  chk_read_float: assert property (
    !card_pins.oe_n |-> card_pins.we_n && !card_pins.ce_n)
    else $error("read without select");
  chk_reset_hold: assert property (
    $rose(card_reset_n) |-> lo_r >= 5'd20) else $error("reset too short");
  chk_reset_quiet: assert property (
    !card_pins.ce_n |-> card_reset_n && fall_r >= 10'd790)
    else $error("card accessed too soon after reset");
  chk_suspend_wait: assert property (
    $fell(card_pins.oe_n) |-> sus_r >= 10'd600)
    else $error("status read too soon after suspend");
endmodule

bind fcesr_host fcesr_monitor u_mon (.clk(clk), .rst_n(rst_n),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .card_pins(card_pins),
  .card_dq_in(card_dq_in), .ready_busy_output(ready_busy_output),
  .card_reset_n(card_reset_n));

// [verification/fcesr_card_model.sv]
// Behavioural word-wide card: command decode, erase suspend, status.
// Assumes the host's clock; one pulse is PULSE_CNT cycles.
`timescale 1ns/100ps
module fcesr_card_model #(parameter int PROG_P = 2, ERASE_P = 4) (
  input wire logic              clk,
  input fcesr_pkg::fcesr_pins_t pins,
  input wire logic              reset_n,
  input wire logic              fail_hi,
  output logic [15:0]           dq,
  output logic                  rb
);
  import fcesr_pkg::*;
  // Start from a quiet, erased card: the host never pulses reset first
  logic [4:0][15:0] h = '0;
  logic [15:0] mw = 16'hFFFF, lastv = 16'h0000, d;
  logic [24:0] ea = '0, ma = '0;
  logic        we_q = 1'b1, oe_q = 1'b1, er = 1'b0, su = 1'b0, tg = 1'b0;
  logic [1:0]  pb = 2'b00;
  int          t = 0, n = 0;
  // Status byte of one lane
  function automatic logic [7:0] lane(input int l);
    logic [7:0] m;
    m = (pins.addr == ma) ? mw[l*8 +: 8] : 8'hFF;
    if (pb[l])
      m = {~mw[l*8+7], tg, fail_hi && l == 1 && n >= PROG_P, 5'h04};
    else if (su && pins.addr[24:16] == ea[24:16])
      m = {2'b11, 3'b000, tg, 2'b00};
    else if (er && !su)
      m = {1'b0, tg, 3'b001, tg, 2'b00};
    return m;
  endfunction
  // Released bus shows the inverse of the last value
  always_comb dq = (!pins.oe_n && !pins.ce_n && reset_n) ?
    {lane(1), lane(0)} : ~lastv;
  assign rb = reset_n && pb == 2'b00 && (!er || su);
  assign d = pins.dq_out;
  // Pulse timing, command decode and reset
  always @(posedge clk) begin
    we_q <= pins.we_n;
    oe_q <= pins.oe_n;
    if (!pins.oe_n) lastv <= dq;
    if (pins.oe_n && !oe_q) tg <= ~tg;
    if (!reset_n) begin
      if (pb != 2'b00) mw <= ~mw;
      {er, su, pb, t, n} <= '0;
    end else begin
      if (pb != 2'b00 || (er && !su)) t <= t + 1;
      if (t == PULSE_CNT - 1) begin
        t <= 0;
        n <= n + 1;
      end
      if (pb[0] && n >= PROG_P) pb[0] <= 1'b0;
      if (pb[1] && n > PROG_P && !fail_hi) pb[1] <= 1'b0;
      if (er && !su && pb == 2'b00 && n >= ERASE_P) er <= 1'b0;
      if (pins.we_n && !we_q && !pins.ce_n) begin
        h <= {h[3:0], d};
        if (h[2] == CMD_UNLOCK1 && h[1] == CMD_UNLOCK2 && h[0] == CMD_PROG
            && pb == 2'b00 && (!er || su)) begin
          {pb, t, n} <= {2'b11, 64'h0};
          mw <= d;
          ma <= pins.addr;
        end else if (su) begin
          if (d == CMD_RESUME) {su, t, n} <= '0;
        end else if (d == CMD_SUSPEND) begin
          if (er) su <= 1'b1;
        end else if (h == {CMD_UNLOCK1, CMD_UNLOCK2, CMD_ESETUP,
            CMD_UNLOCK1, CMD_UNLOCK2} && d == CMD_SECTOR && !er) begin
          {er, t, n} <= {1'b1, 64'h0};
          ea <= pins.addr;
        end
      end
    end
  end
endmodule

// [verification/tb_top.sv]
// Testbench of the flash card host: register port tasks and scenarios.
// Assumes the card model on the pins and the bound checker.
`timescale 1ns/100ps
module tb_top;
  import fcesr_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, fail_hi = 1'b0, rb, crst_n;
  fcesr_req_t  req = '0;
  fcesr_pins_t pins;
  logic [31:0] rdata;
  logic [15:0] dq;
  int bad_count = 0, comparisons = 0;
  // Clock and watchdog
  always #12.5 clk = ~clk;
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
  fcesr_host uut (.clk(clk), .rst_n(rst_n), .reg_req(req),
    .reg_rdata(rdata), .card_pins(pins), .card_dq_in(dq),
    .ready_busy_output(rb), .card_reset_n(crst_n));
  fcesr_card_model card (.clk(clk), .pins(pins), .reset_n(crst_n),
    .fail_hi(fail_hi), .dq(dq), .rb(rb));
  task automatic wrap_up();
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk) req <= '{1'b1, 1'b0, a, v};
    @(posedge clk) req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] g);
    @(posedge clk) req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk) req <= '0;
    #1 g = rdata;
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, e);
    logic [31:0] g;
    rd(a, g);
    chk(g & m, e);
  endtask
  // Start an operation and wait until the host is idle
  task automatic run(input fcesr_op_t op);
    int i;
    logic [31:0] g;
    wr(REG_CTRL, 32'(op));
    for (i = 0; i < 4000; i++) begin
      rd(REG_STATUS, g);
      if (g[ST_BUSY] === 1'b0) break;
    end
    if (i == 4000) begin
      bad_count++;
      wrap_up();
    end
  endtask
  // Main sequence
  initial begin
    int j;
    logic [31:0] g;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rdm(REG_STATUS, 32'h3FF, 32'h200);
    rdm(8'h20, '1, 32'h0);
    run(OP_NONE);
    rdm(REG_STATUS, 32'h81, 32'h80);
    wr(REG_ADDR, 32'h100);
    wr(REG_DATA, 32'h1234);
    rdm(REG_ADDR, '1, 32'h100);
    rdm(REG_DATA, '1, 32'h1234);
    run(OP_PROG);
    rdm(REG_STATUS, 32'h7F, 32'h18);
    rdm(REG_CTRL, '1, 32'h2);
    run(OP_READ);
    rdm(REG_RDATA, 32'hFFFF, 32'h1234);
    run(OP_SUSP);
    rdm(REG_STATUS, 32'h82, 32'h80);
    wr(REG_ADDR, 32'h1_0000);
    run(OP_ERASE);
    rdm(REG_STATUS, 32'h286, 32'h04);
    run(OP_SUSP);
    rdm(REG_STATUS, 32'h386, 32'h306);
    run(OP_ERASE);
    rdm(REG_STATUS, 32'h82, 32'h82);
    run(OP_SUSP);
    rdm(REG_STATUS, 32'h82, 32'h82);
    wr(REG_ADDR, 32'h200);
    wr(REG_DATA, 32'h5AA5);
    run(OP_PROG);
    rdm(REG_STATUS, 32'hFF, 32'h1E);
    run(OP_READ);
    rdm(REG_RDATA, 32'hFFFF, 32'h5AA5);
    wr(REG_ADDR, 32'h1_0000);
    run(OP_RESUME);
    rdm(REG_STATUS, 32'h86, 32'h04);
    run(OP_RESUME);
    rdm(REG_STATUS, 32'h82, 32'h80);
    for (j = 0; j < 40; j++) begin
      repeat (100) @(posedge clk);
      run(OP_POLL);
      rd(REG_STATUS, g);
      if (g[ST_ERASE] === 1'b0) break;
    end
    chk(g & 32'h7E, 32'h18);
    fail_hi <= 1'b1;
    wr(REG_ADDR, 32'h300);
    wr(REG_DATA, 32'h0101);
    run(OP_PROG);
    rdm(REG_STATUS, 32'h7F, 32'h48);
    fail_hi <= 1'b0;
    wr(REG_ADDR, 32'h2_0000);
    run(OP_ERASE);
    run(OP_RESET);
    rdm(REG_STATUS, 32'h207, 32'h200);
    wrap_up();
  end
endmodule
